// ### design/badr_map.svh
// Address map, reset vectors and timing counts for the board glue logic.
`ifndef BADR_MAP_SVH
`define BADR_MAP_SVH

// Monitor EPROM, first part and second part around the control hole.
`define BADR_MON_LO 16'h8000
`define BADR_MON_HI 16'hb3ff
`define BADR_MON2_LO 16'hb800
`define BADR_MON2_HI 16'hbfff
// Special test mode reset vector.
`define BADR_VEC_SPECIAL 16'hbffe
// Normal mode reset vector.
`define BADR_VEC_NORMAL 16'hfffe
// Control window and on-chip EEPROM hole.
`define BADR_CTL_LO 16'hb400
`define BADR_CTL_HI 16'hb5ff
`define BADR_EE_LO 16'hb600
`define BADR_EE_HI 16'hb7ff
// Serial controller and control strobe sub-windows.
`define BADR_SER_PAGE 12'hb40
`define BADR_CTL_PAGE 8'hb5
// Second EPROM.
`define BADR_LA_LO 16'h2000
`define BADR_LA_HI 16'h3fff
// External RAM and its monitor workspace.
`define BADR_RAM_LO 16'hc000
`define BADR_RAM_HI 16'hffff
`define BADR_WS_HI 16'hcfff

// Oscillator: 8 MHz resonator; a bus cycle takes at least three of its periods, E high for one.
`define BADR_CLK_HZ 50000000
`define BADR_OSC_HZ 8000000
`define BADR_OSC_HALF ((`BADR_CLK_HZ / `BADR_OSC_HZ) / 2)
// Reset stretch after the last reset source goes away, in ns.
`define BADR_RST_HOLD_NS 2000
`define BADR_RST_HOLD ((`BADR_RST_HOLD_NS + 19) / 20)
// Configuration programming time in the processor end, in cycles.
`define BADR_CFG_CYC 16
// Watchdog service interval in the processor end, in cycles.
`define BADR_WDOG_CYC 64

`endif

// ### design/badr_pkg.sv
// Types shared by the board end and the processor end.
package badr_pkg;

   // Board reset sequencer.
   typedef enum logic [1:0] {
      BADR_B_RESET = 2'b01,
      BADR_B_RUN = 2'b10
   } badr_board_st_t;

   // Processor end bus and start-up sequencer.
   typedef enum logic [5:0] {
      BADR_M_RESET = 6'b000001,
      BADR_M_CFG = 6'b000010,
      BADR_M_REBOOT = 6'b000100,
      BADR_M_IDLE = 6'b001000,
      BADR_M_ADDR = 6'b010000,
      BADR_M_DATA = 6'b100000
   } badr_mcu_st_t;

   // Operating mode as seen by the processor.
   typedef enum logic [1:0] {
      BADR_MODE_TEST = 2'b01,
      BADR_MODE_EXP = 2'b10
   } badr_mode_t;

endpackage

// ### design/badr_if.sv
// Board bus between the glue logic and the on-board processor.
`timescale 1ns/1ps
interface badr_if;
   // Board side.
   logic osc_clk;
   logic mode_select_a;
   logic mode_select_b;
   logic brd_rst_out;
   logic brd_rst_oe_n;
   logic mon_ce_n;
   logic la_ce_n;
   logic active_high_chip_enable;
   logic ram_ce_n;
   logic ser_ce_n;
   logic ctl_ce_n;
   logic mon_bank;
   logic la_bank;
   logic ram_bank;
   // Processor side.
   logic mcu_rst_out;
   logic mcu_rst_oe_n;
   logic [7:0] addr_hi;
   logic [7:0] ad;
   logic as_strobe;
   logic rw;
   logic e_clk;
   // Shared open-drain reset line, high unless somebody pulls it low.
   wire reset_line_n = (!brd_rst_oe_n && !brd_rst_out) ? 1'b0 :
                       (!mcu_rst_oe_n && !mcu_rst_out) ? 1'b0 : 1'b1;

   modport board (
      output osc_clk, mode_select_a, mode_select_b, brd_rst_out,
      output brd_rst_oe_n, mon_ce_n, la_ce_n, active_high_chip_enable,
      output ram_ce_n, ser_ce_n, ctl_ce_n, mon_bank, la_bank, ram_bank,
      input addr_hi, ad, as_strobe, rw, e_clk, reset_line_n
   );
   modport mcu (
      input osc_clk, mode_select_a, mode_select_b, reset_line_n,
      output mcu_rst_out, mcu_rst_oe_n, addr_hi, ad, as_strobe, rw, e_clk
   );
endinterface

// ### design/badr_board.sv
// Board glue: mode straps, reset sources, oscillator and address decode.
`timescale 1ns/1ps
`include "badr_map.svh"
module badr_board (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   badr_if.board bus,
   input wire logic i_supply_above_lo,
   input wire logic i_supply_above_hi,
   input wire logic i_reset_sw_n,
   input wire logic i_user_reset_sw_n,
   input wire logic i_ext_clk_sel,
   input wire logic i_ext_clk,
   input wire logic [2:0] i_bank_port,
   output logic o_under_voltage,
   output logic o_in_reset
);

   localparam int NSYNC = 9;
   // Synchronisers reset to each pin's idle level. Both switches idle high,
   // so no false press reaches the strap logic just after reset.
   localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h00c;
   localparam logic [7:0] HOLD_CYC = 8'(`BADR_RST_HOLD);
   localparam logic [7:0] OSC_HALF = 8'(`BADR_OSC_HALF);

   // Every pin input except the processor bus passes two flip-flops before anything reads it.
   logic [NSYNC-1:0] sync_raw;
   logic [NSYNC-1:0] sync_m;
   logic [NSYNC-1:0] sync_q;
   assign sync_raw = {i_bank_port, i_ext_clk, i_ext_clk_sel,
                      i_user_reset_sw_n, i_reset_sw_n,
                      i_supply_above_hi, i_supply_above_lo};

   // One two-stage synchroniser per pin.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               sync_m[gi] <= SYNC_IDLE[gi];
               sync_q[gi] <= SYNC_IDLE[gi];
            end else begin
               sync_m[gi] <= sync_raw[gi];
               sync_q[gi] <= sync_m[gi];
            end
         end
      end
   endgenerate

   wire above_lo = sync_q[0];
   wire above_hi = sync_q[1];
   wire reset_sw = !sync_q[2];
   wire user_sw = !sync_q[3];
   wire ext_sel = sync_q[4];
   wire ext_clk = sync_q[5];
   wire [2:0] bank_port = sync_q[8:6];

   // Under-voltage detector with two thresholds. It trips below the low
   // one and clears only above the high one, so supply noise on a slow
   // ramp cannot start and stop the processor repeatedly.
   logic uv;
   wire next_uv = uv ? !above_hi : !above_lo;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         uv <= 1'b1;
      end else begin
         uv <= next_uv;
      end
   end

   // Reset sources: under-voltage, reset switch, and the switch pair.
   wire rst_src = uv || reset_sw;
   wire both_sw = reset_sw && user_sw;

   // Reset sequencer; the line is held for a short stretch after the last
   // source goes away so the straps are stable well past the release.
   badr_pkg::badr_board_st_t st;
   badr_pkg::badr_board_st_t next_st;
   logic [7:0] hold;
   logic [7:0] next_hold;
   always_comb begin
      next_st = st;
      next_hold = hold;
      case (st)
         badr_pkg::BADR_B_RESET: begin
            if (rst_src) begin
               next_hold = HOLD_CYC;
            end else if (hold > 8'h01) begin
               next_hold = hold - 8'h01;
            end else begin
               next_hold = 8'h00;
               next_st = badr_pkg::BADR_B_RUN;
            end
         end
         badr_pkg::BADR_B_RUN: begin
            if (rst_src) begin
               next_hold = HOLD_CYC;
               next_st = badr_pkg::BADR_B_RESET;
            end
         end
         default: begin
            next_hold = HOLD_CYC;
            next_st = badr_pkg::BADR_B_RESET;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= badr_pkg::BADR_B_RESET;
         hold <= 8'(`BADR_RST_HOLD);
      end else begin
         st <= next_st;
         hold <= next_hold;
      end
   end

   // An ordinary reset from run clears strap b; a press of the switch pair
   // during reset sets it and it holds through release, since the user has
   // let go of the switches long before the reset stretch ends.
   logic mode_b;
   wire next_mode_b = (st == badr_pkg::BADR_B_RUN) ?
                      (rst_src ? both_sw : mode_b) : (mode_b || both_sw);
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_b <= 1'b0;
      end else begin
         mode_b <= next_mode_b;
      end
   end
   assign bus.mode_select_a = 1'b1;
   assign bus.mode_select_b = mode_b;

   // Open-drain reset drive: low, with the enable active, while in reset.
   logic rst_drv;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_drv <= 1'b1;
      end else begin
         rst_drv <= (next_st == badr_pkg::BADR_B_RESET);
      end
   end
   assign bus.brd_rst_out = 1'b0;
   assign bus.brd_rst_oe_n = !rst_drv;
   assign o_in_reset = rst_drv;
   assign o_under_voltage = uv;

   // Oscillator: the on-board resonator is modelled by a divider of the
   // core clock; the jumper hands the pin over to an external clock.
   logic [7:0] osc_cnt;
   logic osc_int;
   logic osc_out;
   wire osc_wrap = (osc_cnt >= OSC_HALF - 8'h01);
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         osc_cnt <= 8'h00;
         osc_int <= 1'b0;
         osc_out <= 1'b0;
      end else begin
         osc_cnt <= osc_wrap ? 8'h00 : osc_cnt + 8'h01;
         osc_int <= osc_wrap ? !osc_int : osc_int;
         osc_out <= ext_sel ? ext_clk : osc_int;
      end
   end
   assign bus.osc_clk = osc_out;

   // Demultiplex: the low address byte is caught while the strobe is high.
   logic [7:0] addr_lo;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_lo <= 8'h00;
      end else if (bus.as_strobe) begin
         addr_lo <= bus.ad;
      end
   end

   // Decoding on the demultiplexed address. Selects only count while the
   // E-clock is high, so a device never drives during the address phase.
   wire [15:0] addr = {bus.addr_hi, addr_lo};
   wire rd = bus.e_clk && bus.rw;
   wire cyc = bus.e_clk;
   wire hit_mon = ((addr >= `BADR_MON_LO) && (addr <= `BADR_MON_HI)) ||
                  ((addr >= `BADR_MON2_LO) && (addr <= `BADR_MON2_HI));
   wire hit_la = (addr >= `BADR_LA_LO) && (addr <= `BADR_LA_HI);
   wire hit_ram = (addr >= `BADR_RAM_LO) && (addr <= `BADR_RAM_HI);
   wire hit_ser = (addr[15:4] == `BADR_SER_PAGE);
   wire hit_ctl = (addr[15:8] == `BADR_CTL_PAGE);
   // The vector bytes at the top of the monitor region fall inside hit_mon.
   wire next_mon_ce_n = !(rd && hit_mon);
   wire next_la_dec_n = !(rd && hit_la);
   wire next_la_hi = addr[13];
   wire next_ram_ce_n = !(cyc && hit_ram);
   wire next_ser_ce_n = !(cyc && hit_ser);
   wire next_ctl_ce_n = !(cyc && hit_ctl);

   // Enables are flopped so each pin is glitch-free; they trail the bus by
   // one core clock, which is far shorter than an E-clock phase.
   logic mon_ce_n;
   logic la_ce_n;
   logic la_ce_hi;
   logic ram_ce_n;
   logic ser_ce_n;
   logic ctl_ce_n;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mon_ce_n <= 1'b1;
         la_ce_n <= 1'b1;
         la_ce_hi <= 1'b0;
         ram_ce_n <= 1'b1;
         ser_ce_n <= 1'b1;
         ctl_ce_n <= 1'b1;
      end else begin
         mon_ce_n <= next_mon_ce_n;
         la_ce_n <= next_la_dec_n;
         la_ce_hi <= next_la_hi;
         ram_ce_n <= next_ram_ce_n;
         ser_ce_n <= next_ser_ce_n;
         ctl_ce_n <= next_ctl_ce_n;
      end
   end
   assign bus.mon_ce_n = mon_ce_n;
   assign bus.la_ce_n = la_ce_n;
   assign bus.active_high_chip_enable = la_ce_hi;
   assign bus.ram_ce_n = ram_ce_n;
   assign bus.ser_ce_n = ser_ce_n;
   assign bus.ctl_ce_n = ctl_ce_n;

   // Bank lines come straight from the serial controller's output port.
   logic [2:0] bank;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bank <= 3'h0;
      end else begin
         bank <= bank_port;
      end
   end
   assign bus.mon_bank = bank[0];
   assign bus.la_bank = bank[1];
   assign bus.ram_bank = bank[2];

endmodule

// ### design/badr_mcu.sv
// Processor end: start-up sequence and multiplexed bus cycles.
`timescale 1ns/1ps
`include "badr_map.svh"
module badr_mcu (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   badr_if.mcu bus,
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   input wire logic i_rw,
   input wire logic i_cfg_req,
   input wire logic i_wdog_en,
   input wire logic i_ee_over_mon,
   output logic o_done,
   output logic o_ready,
   output logic [1:0] o_mode,
   output logic o_irv,
   output logic o_ws_hit,
   output logic o_wdog_kick,
   output logic o_ee_on
);

   badr_pkg::badr_mcu_st_t st;
   badr_pkg::badr_mcu_st_t next_st;
   logic osc_q;
   logic [7:0] cnt;
   logic cfg_done;
   logic [15:0] cur_addr;
   logic cur_rw;
   logic [7:0] wd_cnt;
   wire osc_rise = bus.osc_clk && !osc_q;
   wire in_reset = !bus.reset_line_n;
   wire test_strap = bus.mode_select_a && !bus.mode_select_b;
   wire start = (st == badr_pkg::BADR_M_IDLE) &&
                (next_st == badr_pkg::BADR_M_ADDR);

   // Start-up and bus sequencer; each bus phase lasts to the next
   // oscillator rising edge.
   always_comb begin
      next_st = st;
      case (st)
         badr_pkg::BADR_M_RESET: begin
            if (!in_reset) begin
               // A pending configuration change is handled from test mode.
               next_st = (test_strap && i_cfg_req && !cfg_done) ?
                         badr_pkg::BADR_M_CFG : badr_pkg::BADR_M_IDLE;
            end
         end
         badr_pkg::BADR_M_CFG: begin
            if (cnt == 8'h00) begin
               next_st = badr_pkg::BADR_M_REBOOT;
            end
         end
         badr_pkg::BADR_M_REBOOT: begin
            if (in_reset) begin
               next_st = badr_pkg::BADR_M_RESET;
            end
         end
         badr_pkg::BADR_M_IDLE: begin
            if (i_req && osc_rise) begin
               next_st = badr_pkg::BADR_M_ADDR;
            end
         end
         badr_pkg::BADR_M_ADDR: begin
            if (osc_rise) begin
               next_st = badr_pkg::BADR_M_DATA;
            end
         end
         badr_pkg::BADR_M_DATA: begin
            if (osc_rise) begin
               next_st = badr_pkg::BADR_M_IDLE;
            end
         end
         default: begin
            next_st = badr_pkg::BADR_M_RESET;
         end
      endcase
      if (in_reset && st != badr_pkg::BADR_M_REBOOT) begin
         next_st = badr_pkg::BADR_M_RESET;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= badr_pkg::BADR_M_RESET;
         osc_q <= 1'b0;
      end else begin
         st <= next_st;
         osc_q <= bus.osc_clk;
      end
   end

   // Configuration programming time and the done flag that stops a loop.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 8'h00;
         cfg_done <= 1'b0;
      end else if (st != badr_pkg::BADR_M_CFG) begin
         cnt <= 8'(`BADR_CFG_CYC);
         cfg_done <= cfg_done && i_cfg_req;
      end else begin
         cnt <= cnt - 8'h01;
         cfg_done <= 1'b1;
      end
   end

   // Mode: test mode while in reset whatever the straps, then firmware leaves test
   // mode for expanded mode with visibility of internal reads turned on.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mode <= badr_pkg::BADR_MODE_TEST;
         o_irv <= 1'b0;
         o_ee_on <= 1'b1;
      end else if (st == badr_pkg::BADR_M_RESET) begin
         o_mode <= badr_pkg::BADR_MODE_TEST;
         o_irv <= 1'b0;
         o_ee_on <= 1'b1;
      end else if (st == badr_pkg::BADR_M_IDLE) begin
         o_mode <= badr_pkg::BADR_MODE_EXP;
         o_irv <= 1'b1;
         o_ee_on <= o_ee_on && !i_ee_over_mon;
      end
   end

   // Bus cycle: address and strobe, then data phase with E high.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cur_addr <= 16'h0000;
         cur_rw <= 1'b1;
         o_done <= 1'b0;
         o_ws_hit <= 1'b0;
      end else begin
         if (start) begin
            cur_addr <= i_addr;
            cur_rw <= i_rw;
            o_ws_hit <= (i_addr >= `BADR_RAM_LO) &&
                        (i_addr <= `BADR_WS_HI);
         end
         o_done <= (st == badr_pkg::BADR_M_DATA) &&
                   (next_st == badr_pkg::BADR_M_IDLE);
      end
   end
   assign o_ready = (st == badr_pkg::BADR_M_IDLE);
   assign bus.addr_hi = cur_addr[15:8];
   assign bus.ad = cur_addr[7:0];
   assign bus.as_strobe = (st == badr_pkg::BADR_M_ADDR);
   assign bus.rw = cur_rw;
   assign bus.e_clk = (st == badr_pkg::BADR_M_DATA);

   // Forced reset after configuration: pull the shared line low.
   assign bus.mcu_rst_out = 1'b0;
   assign bus.mcu_rst_oe_n = (st != badr_pkg::BADR_M_REBOOT);

   // Watchdog service while it is enabled and firmware is running.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wd_cnt <= 8'h00;
         o_wdog_kick <= 1'b0;
      end else begin
         o_wdog_kick <= 1'b0;
         if (!i_wdog_en || st == badr_pkg::BADR_M_RESET) begin
            wd_cnt <= 8'h00;
         end else if (wd_cnt == 8'(`BADR_WDOG_CYC - 1)) begin
            wd_cnt <= 8'h00;
            o_wdog_kick <= 1'b1;
         end else begin
            wd_cnt <= wd_cnt + 8'h01;
         end
      end
   end

endmodule

// ### tb/badr_props.sv
// Concurrent checks on the bus between the glue logic and the processor.
`timescale 1ns/1ps
module badr_props (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic mode_select_a,
   input wire logic mode_select_b,
   input wire logic brd_rst_out,
   input wire logic brd_rst_oe_n,
   input wire logic mon_ce_n,
   input wire logic la_ce_n,
   input wire logic active_high_chip_enable,
   input wire logic ram_ce_n,
   input wire logic ser_ce_n,
   input wire logic ctl_ce_n,
   input wire logic [7:0] addr_hi,
   input wire logic [7:0] ad,
   input wire logic as_strobe,
   input wire logic rw,
   input wire logic e_clk,
   input wire logic reset_line_n
);
   logic [7:0] lo;
   // Predicted selects; a stale low byte would make these disagree.
   wire [15:0] a = {addr_hi, lo};
   wire rd = e_clk && rw;
   wire mon_hit = rd && (a inside {[16'h8000:16'hb3ff],
      [16'hb800:16'hbfff]});
   wire la_hit = rd && (a inside {[16'h2000:16'h3fff]});
   wire ram_hit = e_clk && a >= 16'hc000;
   wire ee_hit = e_clk && (a inside {[16'hb600:16'hb7ff]});
   wire ctl_hit = e_clk && (a inside {[16'hb400:16'hb5ff]});
   wire mem_off = mon_ce_n && la_ce_n && ram_ce_n;
   wire all_off = mem_off && ser_ce_n && ctl_ce_n;

   // Own copy of the low address latch, taken while the strobe is high.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         lo <= 8'h00;
      else if (as_strobe)
         lo <= ad;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // Close of a data phase.
   sequence s_data_end;
      e_clk ##1 !e_clk;
   endsequence

   chk_mon_read: assert property (mon_ce_n == !$past(mon_hit))
      else $error("monitor EPROM select wrong");
   chk_la_read: assert property (la_ce_n == !$past(la_hit))
      else $error("second EPROM select wrong");
   chk_ram_both: assert property (ram_ce_n == !$past(ram_hit))
      else $error("RAM select wrong");
   chk_ee_quiet: assert property ($past(ee_hit) |-> all_off)
      else $error("select active in EEPROM hole");
   chk_ctl_nomem: assert property ($past(ctl_hit) |-> mem_off)
      else $error("memory select in control window");
   chk_a13_high: assert property (!la_ce_n |->
      active_high_chip_enable)
      else $error("high enable low during second EPROM cycle");
   chk_single_drive: assert property ($onehot0(~{mon_ce_n, la_ce_n,
      ram_ce_n, ser_ce_n, ctl_ce_n}))
      else $error("more than one select active");
   chk_cycle_release: assert property (s_data_end |=> all_off)
      else $error("select held after data phase");
   chk_strap_a: assert property (mode_select_a)
      else $error("mode strap a low");
   chk_board_pull: assert property (!brd_rst_oe_n |->
      !brd_rst_out && !reset_line_n)
      else $error("board drive does not pull reset low");
   chk_strap_hold: assert property (brd_rst_oe_n &&
      $past(brd_rst_oe_n) |-> $stable(mode_select_b))
      else $error("mode strap b moved while running");
endmodule

// ### tb/board_address_decode_reset_tb.sv
// Bench that joins the glue logic to the processor end and checks both.
`timescale 1ns/1ps
module board_address_decode_reset_tb;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_supply_above_lo = 1'b1;
   logic i_supply_above_hi = 1'b1;
   logic i_reset_sw_n = 1'b1;
   logic i_user_reset_sw_n = 1'b1;
   logic [2:0] i_bank_port = 3'h0;
   logic i_ext_clk_sel = 1'b0;
   logic i_ext_clk = 1'b0;
   logic i_req = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic i_rw = 1'b1;
   logic i_cfg_req = 1'b0;
   logic i_wdog_en = 1'b0;
   logic i_ee_over_mon = 1'b0;
   logic o_done, o_ready, o_irv, o_ws_hit, o_wdog_kick, o_ee_on;
   logic o_under_voltage, o_in_reset;
   logic [1:0] o_mode;
   logic [4:0] seen;
   int errors = 0;
   int tests_run = 0;
   int n;
   // Bit 16 set means a read cycle.
   localparam logic [16:0] map_tbl [21] = '{17'h18000, 17'h1b3ff,
      17'h1b400, 17'h1b40f, 17'h1b500, 17'h1b5ff, 17'h1b600, 17'h1b7ff,
      17'h1b800, 17'h1bffe, 17'h1bfff, 17'h08000, 17'h12000, 17'h13fff,
      17'h11fff, 17'h14000, 17'h02000, 17'h0c000, 17'h1ffff, 17'h1cfff,
      17'h0b400};
   badr_if bus ();

   // The external clock jumper is driven so both clock sources are seen.
   badr_board badr_board_i (.i_core_clk, .i_rst_n, .bus(bus.board),
      .i_supply_above_lo, .i_supply_above_hi, .i_reset_sw_n,
      .i_user_reset_sw_n, .i_ext_clk_sel, .i_ext_clk,
      .i_bank_port, .o_under_voltage, .o_in_reset);
   badr_mcu badr_mcu_i (.i_core_clk, .i_rst_n, .bus(bus.mcu), .i_req,
      .i_addr, .i_rw, .i_cfg_req, .i_wdog_en, .i_ee_over_mon, .o_done,
      .o_ready, .o_mode, .o_irv, .o_ws_hit, .o_wdog_kick, .o_ee_on);
   badr_props badr_props_i (.i_core_clk, .i_rst_n,
      .mode_select_a(bus.mode_select_a), .mode_select_b(bus.mode_select_b),
      .brd_rst_out(bus.brd_rst_out), .brd_rst_oe_n(bus.brd_rst_oe_n),
      .mon_ce_n(bus.mon_ce_n), .la_ce_n(bus.la_ce_n),
      .active_high_chip_enable(bus.active_high_chip_enable),
      .ram_ce_n(bus.ram_ce_n), .ser_ce_n(bus.ser_ce_n),
      .ctl_ce_n(bus.ctl_ce_n), .addr_hi(bus.addr_hi), .ad(bus.ad),
      .as_strobe(bus.as_strobe), .rw(bus.rw), .e_clk(bus.e_clk),
      .reset_line_n(bus.reset_line_n));

   // Core clock at 50 MHz.
   initial begin
      forever #10 i_core_clk = ~i_core_clk;
   end

   // Counts one comparison and reports a difference at once.
   task automatic check(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Inputs move only on falling edges, clear of the sampling edge.
   task automatic tick(input int c);
      repeat (c) @(negedge i_core_clk);
   endtask

   task automatic wait_ready();
      for (n = 0; n < 800 && o_ready !== 1'b1; n++)
         tick(1);
      check("ready", 8'h01, 8'(o_ready));
   endtask

   task automatic sample();
      seen |= ~{bus.mon_ce_n, bus.la_ce_n, bus.ram_ce_n, bus.ser_ce_n,
         bus.ctl_ce_n};
   endtask

   // Selects that the map calls for, one bit per device.
   function automatic logic [4:0] sel(input logic [15:0] a, input logic r);
      sel[4] = r && (a inside {[16'h8000:16'hb3ff], [16'hb800:16'hbfff]});
      sel[3] = r && (a inside {[16'h2000:16'h3fff]});
      sel[2] = a >= 16'hc000;
      sel[1] = a inside {[16'hb400:16'hb40f]};
      sel[0] = a inside {[16'hb500:16'hb5ff]};
   endfunction

   // One bus cycle; the request is held until the processor takes it.
   task automatic cycle(input logic [15:0] a, input logic r);
      wait_ready();
      seen = 5'h00;
      i_req = 1'b1;
      i_addr = a;
      i_rw = r;
      for (n = 0; n < 60 && o_done !== 1'b1; n++) begin
         tick(1);
         if (o_ready !== 1'b1)
            i_req = 1'b0;
         sample();
      end
      check("done", 8'h01, 8'(o_done));
      tick(1);
      sample();
      tick(1);
      sample();
   endtask

   task automatic t_reset();
      tick(8);
      check("strap a", 8'h01, 8'(bus.mode_select_a));
      check("strap b", 8'h00, 8'(bus.mode_select_b));
      check("line", 8'h00, 8'(bus.reset_line_n));
      tick(8);
      i_rst_n = 1'b1;
      tick(30);
      check("stretch", 8'h00, 8'(bus.reset_line_n));
      wait_ready();
      // The mode register follows one edge after idle is reached.
      tick(1);
      check("mode", 8'h02, 8'(o_mode));
      check("visibility", 8'h01, 8'(o_irv));
   endtask

   task automatic t_osc();
      int r0, r1;
      logic p;
      r0 = 0;
      r1 = 0;
      p = bus.osc_clk;
      for (n = 0; n < 20; n++) begin
         tick(1);
         if (bus.osc_clk === 1'b1 && p === 1'b0) begin
            r0 = r1;
            r1 = n;
         end
         p = bus.osc_clk;
      end
      check("osc period", 8'h06, 8'(r1 - r0));
      i_ext_clk_sel = 1'b1;
      i_ext_clk = 1'b1;
      tick(6);
      check("ext clk", 8'h01, 8'(bus.osc_clk));
      i_ext_clk = 1'b0;
      tick(6);
      check("ext clk", 8'h00, 8'(bus.osc_clk));
      i_ext_clk_sel = 1'b0;
   endtask

   // Map edges, holes and refused writes, back to back.
   task automatic t_map();
      logic [4:0] w;
      for (int k = 0; k < 21; k++) begin
         cycle(map_tbl[k][15:0], map_tbl[k][16]);
         w = sel(map_tbl[k][15:0], map_tbl[k][16]);
         check("sel", 8'(w), 8'(seen));
         check("sel mon", 8'(w[4]), 8'(seen[4]));
         check("ws", 8'(map_tbl[k][15:12] == 4'hc), 8'(o_ws_hit));
      end
   endtask

   task automatic t_bank();
      logic [2:0] got;
      for (int k = 0; k < 4; k++) begin
         i_bank_port = 3'h1 << k;
         tick(6);
         got = {bus.ram_bank, bus.la_bank, bus.mon_bank};
         check("bank", 8'(i_bank_port), 8'(got));
      end
   endtask

   // Watchdog rate, then the overlapping EEPROM is switched off.
   task automatic t_fw();
      int kicks;
      kicks = 0;
      i_wdog_en = 1'b1;
      tick(70);
      repeat (128) begin
         tick(1);
         kicks += int'(o_wdog_kick === 1'b1);
      end
      check("kicks", 8'h02, 8'(kicks));
      i_ee_over_mon = 1'b1;
      tick(8);
      check("eeprom", 8'h00, 8'(o_ee_on));
   endtask

   task automatic t_switch();
      i_reset_sw_n = 1'b0;
      tick(8);
      check("line", 8'h00, 8'(bus.reset_line_n));
      check("strap b", 8'h00, 8'(bus.mode_select_b));
      i_user_reset_sw_n = 1'b0;
      tick(8);
      check("strap b", 8'h01, 8'(bus.mode_select_b));
      i_reset_sw_n = 1'b1;
      i_user_reset_sw_n = 1'b1;
      wait_ready();
      check("strap held", 8'h01, 8'(bus.mode_select_b));
   endtask

   // Low supply latches until the upper threshold is passed.
   task automatic t_uv();
      i_supply_above_lo = 1'b0;
      i_supply_above_hi = 1'b0;
      tick(6);
      check("under", 8'h01, 8'(o_under_voltage));
      check("line", 8'h00, 8'(bus.reset_line_n));
      i_supply_above_lo = 1'b1;
      tick(20);
      check("hysteresis", 8'h01, 8'(o_under_voltage));
      i_supply_above_hi = 1'b1;
      tick(8);
      check("under", 8'h00, 8'(o_under_voltage));
      check("in reset", 8'h01, 8'(o_in_reset));
      wait_ready();
   endtask

   // A pending change must end in a reset forced by the processor.
   task automatic t_cfg();
      logic hit;
      hit = 1'b0;
      i_cfg_req = 1'b1;
      i_reset_sw_n = 1'b0;
      tick(8);
      i_reset_sw_n = 1'b1;
      for (n = 0; n < 800; n++) begin
         tick(1);
         hit |= !bus.mcu_rst_oe_n && !o_in_reset && !bus.reset_line_n;
      end
      check("reboot", 8'h01, 8'(hit));
      i_cfg_req = 1'b0;
      wait_ready();
   endtask

   // Hang guard, several times the few thousand cycles of a normal run.
   initial begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      final_report();
   end

   initial begin
      t_reset();
      t_osc();
      t_map();
      t_bank();
      t_fw();
      t_switch();
      t_uv();
      t_cfg();
      final_report();
   end
endmodule
